/* hdl/srw_params.svh */
// Timing constants for the supervisor reset watchdog
`ifndef SRW_PARAMS_SVH
`define SRW_PARAMS_SVH
`define SRW_CLK_MHZ 125
`define SRW_RST_SHORT_MS 50
`define SRW_RST_LONG_MS 200
`define SRW_WD_LONG_MS 1600
`define SRW_WD_SHORT_MS 100
`define SRW_PRESCALE 64
`define SRW_EXT_LONG_TICKS 64
`define SRW_EXT_SHORT_TICKS 16
`define SRW_EXT_RST_TICKS 16
`define SRW_MS_CYCLES (`SRW_CLK_MHZ * 1000)
`endif

/* hdl/srw_pkg.sv */
// Types for the supervisor reset watchdog
package srw_pkg;
  typedef enum logic [1:0] {
    SRW_ST_RESET = 2'b00,
    SRW_ST_RUN = 2'b01,
    SRW_ST_BACKUP = 2'b10
  } srw_state_t;
endpackage

/* hdl/srw_supervisor.sv */
// Supervisor: reset pulse generator, watchdog and chip-select gate
`include "srw_params.svh"
module srw_supervisor #(
  parameter bit LONG_VARIANT = 1'b0,
  parameter int MS_CYCLES = `SRW_MS_CYCLES,
  parameter int RST_MS_SHORT = `SRW_RST_SHORT_MS,
  parameter int RST_MS_LONG = `SRW_RST_LONG_MS,
  parameter int WD_MS_LONG = `SRW_WD_LONG_MS,
  parameter int WD_MS_SHORT = `SRW_WD_SHORT_MS,
  parameter int EXT_LONG = `SRW_EXT_LONG_TICKS,
  parameter int EXT_SHORT = `SRW_EXT_SHORT_TICKS,
  parameter int EXT_RST = `SRW_EXT_RST_TICKS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic supply_low,
  input wire logic backup_active,
  input wire logic watchdog_kick_in,
  input wire logic watchdog_kick_float,
  input wire logic chip_select_n_in,
  input wire logic timebase_select,
  input wire logic timebase_input,
  input wire logic power_warn_sense,
  output logic reset_n,
  output logic reset_hi,
  output logic low_line_n,
  output logic watchdog_expired_n,
  output logic chip_select_n_out,
  output logic power_warn_n,
  output srw_pkg::srw_state_t state
);
  import srw_pkg::*;

  // ****************
  // Timebase
  // ****************
  srw_tick_if tick ();
  srw_timebase #(.MS_CYCLES(MS_CYCLES)) u_tb (
    .clk(clk),
    .rst(rst),
    .ext_clk(timebase_input),
    .tick(tick)
  );

  logic use_ext;
  logic tb_tick;
  logic [31:0] rst_len, wd_len;
  logic [31:0] rst_cnt_reg, wd_cnt_reg;
  logic kick_s1_reg, kick_s2_reg, kick_d_reg, flt_s1_reg, flt_s2_reg;
  logic short_ok_reg;
  logic kick_edge, wd_off, timeout;
  srw_state_t state_reg, state_next;

  // Tick source follows the timebase select
  assign use_ext = !timebase_select;
  assign tb_tick = use_ext ? tick.ext_tick : tick.ms_tick;
  assign rst_len = use_ext ? 32'(EXT_RST)
    : (LONG_VARIANT ? 32'(RST_MS_LONG) : 32'(RST_MS_SHORT));
  // External clock level carries no period choice
  always_comb begin
    if (use_ext) begin
      wd_len = short_ok_reg ? 32'(EXT_SHORT) : 32'(EXT_LONG);
    end else begin
      wd_len = (short_ok_reg && !timebase_input) ? 32'(WD_MS_SHORT) : 32'(WD_MS_LONG);
    end
  end

  // ****************
  // Kick synchroniser
  // ****************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      kick_s1_reg <= 1'b0;
      kick_s2_reg <= 1'b0;
      kick_d_reg <= 1'b0;
      flt_s1_reg <= 1'b1;
      flt_s2_reg <= 1'b1;
    end else begin
      kick_s1_reg <= watchdog_kick_in;
      kick_s2_reg <= kick_s1_reg;
      kick_d_reg <= kick_s2_reg;
      flt_s1_reg <= watchdog_kick_float;
      flt_s2_reg <= flt_s1_reg;
    end
  end
  // Kick edges count only while the pin is driven
  assign kick_edge = (kick_s2_reg != kick_d_reg) && !flt_s2_reg && !backup_active;
  assign wd_off = flt_s2_reg || supply_low || backup_active || state_reg != SRW_ST_RUN;
  assign timeout = !wd_off && tb_tick && (wd_cnt_reg + 32'h1 >= wd_len);

  // ****************
  // State machine
  // ****************
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SRW_ST_RESET: begin
        if (backup_active) begin
          state_next = SRW_ST_BACKUP;
        end else if (!supply_low && tb_tick && rst_cnt_reg + 32'h1 >= rst_len) begin
          state_next = SRW_ST_RUN;
        end
      end
      SRW_ST_RUN: begin
        if (backup_active) begin
          state_next = SRW_ST_BACKUP;
        end else if (supply_low || timeout) begin
          state_next = SRW_ST_RESET;
        end
      end
      SRW_ST_BACKUP: begin
        if (!backup_active) begin
          state_next = SRW_ST_RESET;
        end
      end
      // Illegal code falls back to the reset pulse
      default: begin
        state_next = SRW_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= SRW_ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************
  // Counters
  // ****************
  // Reset pulse counter restarts while supply is low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rst_cnt_reg <= 32'h0;
    end else if (state_reg != SRW_ST_RESET || supply_low) begin
      rst_cnt_reg <= 32'h0;
    end else if (tb_tick) begin
      rst_cnt_reg <= rst_cnt_reg + 32'h1;
    end
  end

  // Watchdog counter, restarted by every kick edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wd_cnt_reg <= 32'h0;
    end else if (wd_off || kick_edge || timeout) begin
      wd_cnt_reg <= 32'h0;
    end else if (tb_tick) begin
      wd_cnt_reg <= wd_cnt_reg + 32'h1;
    end
  end

  // Short period armed by first kick after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      short_ok_reg <= 1'b0;
    end else if (state_reg != SRW_ST_RUN) begin
      short_ok_reg <= 1'b0;
    end else if (kick_edge) begin
      short_ok_reg <= 1'b1;
    end
  end

  // ****************
  // Outputs
  // ****************
  // Reset outputs and state follow the next state so they move together
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_n <= 1'b0;
      reset_hi <= 1'b1;
      low_line_n <= 1'b0;
      power_warn_n <= 1'b0;
      chip_select_n_out <= 1'b1;
      state <= SRW_ST_RESET;
    end else begin
      reset_n <= (state_next == SRW_ST_RUN);
      reset_hi <= (state_next != SRW_ST_RUN);
      low_line_n <= !(supply_low || backup_active);
      power_warn_n <= power_warn_sense && !backup_active;
      chip_select_n_out <= (supply_low || backup_active) ? 1'b1 : chip_select_n_in;
      state <= state_next;
    end
  end

  // ****************
  // Watchdog expired flag
  // ****************
  // A timeout wins over a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      watchdog_expired_n <= 1'b1;
    end else if (timeout) begin
      watchdog_expired_n <= 1'b0;
    end else if (kick_edge || supply_low || backup_active) begin
      watchdog_expired_n <= 1'b1;
    end
  end
endmodule

/* hdl/srw_tick_if.sv */
// Timebase ticks passed from the timebase to the supervisor
interface srw_tick_if;
  logic ms_tick;
  logic ext_tick;
  modport src (output ms_tick, output ext_tick);
  modport dst (input ms_tick, input ext_tick);
endinterface

/* hdl/srw_timebase.sv */
// Millisecond tick and external clock prescaler
`include "srw_params.svh"
module srw_timebase #(
  parameter int MS_CYCLES = `SRW_MS_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ext_clk,
  srw_tick_if.src tick
);
  logic [31:0] ms_cnt_reg;
  logic [5:0] pre_cnt_reg;
  logic ext_s1_reg, ext_s2_reg, ext_d_reg;

  // Internal oscillator tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ms_cnt_reg <= 32'h0;
      tick.ms_tick <= 1'b0;
    end else if (ms_cnt_reg >= 32'(MS_CYCLES - 1)) begin
      ms_cnt_reg <= 32'h0;
      tick.ms_tick <= 1'b1;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 32'h1;
      tick.ms_tick <= 1'b0;
    end
  end

  // External clock synchroniser and divide by 64
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_d_reg <= 1'b0;
      pre_cnt_reg <= 6'h0;
      tick.ext_tick <= 1'b0;
    end else begin
      ext_s1_reg <= ext_clk;
      ext_s2_reg <= ext_s1_reg;
      ext_d_reg <= ext_s2_reg;
      tick.ext_tick <= 1'b0;
      if (ext_s2_reg && !ext_d_reg) begin
        pre_cnt_reg <= pre_cnt_reg + 6'h1;
        if (pre_cnt_reg == 6'(`SRW_PRESCALE - 1)) begin
          tick.ext_tick <= 1'b1;
        end
      end
    end
  end
endmodule

/* sim/srw_host_model.sv */
// Host model that services the watchdog kick input
module srw_host_model (
  input wire logic clk,
  input wire logic run,
  input wire logic float_req,
  output logic kick = 1'b0,
  output logic kick_float = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] gap_reg = 4'h0;
  always @(posedge clk) begin
    gap_reg <= gap_reg + 4'h1;
    kick_float <= #1 float_req;
    if (float_req && !kick_float) kick <= #1 !kick;
    else if (run && !float_req && gap_reg == 4'hf) kick <= #1 !kick;
  end
endmodule

/* sim/srw_supervisor_asserts.sv */
// Assertions on the supervisor ports
module srw_supervisor_asserts #(
  parameter int MS_CYCLES = 4,
  parameter int RST_MS_SHORT = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic supply_low,
  input wire logic backup_active,
  input wire logic chip_select_n_in,
  input wire logic timebase_select,
  input wire logic reset_n,
  input wire logic reset_hi,
  input wire logic low_line_n,
  input wire logic watchdog_expired_n,
  input wire logic chip_select_n_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [31:0] low_cnt_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt_reg <= 32'h0;
    end else if (reset_n) begin
      low_cnt_reg <= 32'h0;
    end else begin
      low_cnt_reg <= low_cnt_reg + 32'h1;
    end
  end
  reset_pair_a: assert property (reset_hi == !reset_n) else $error("reset outputs disagree");
  reset_fast_a: assert property (supply_low |=> !reset_n) else $error("reset late");
  cs_block_a: assert property (supply_low |=> chip_select_n_out) else $error("select not blocked");
  cs_copy_a: assert property (!supply_low && !backup_active |=> chip_select_n_out == $past(chip_select_n_in))
    else $error("select not copied");
  line_free_a: assert property (!supply_low && !backup_active |=> low_line_n) else $error("line low");
  expired_clear_a: assert property (supply_low |=> watchdog_expired_n) else $error("expired held");
  backup_fix_a: assert property (backup_active |=> !reset_n && watchdog_expired_n && chip_select_n_out)
    else $error("backup outputs wrong");
  pulse_len_a: assert property ($rose(reset_n) && timebase_select |-> low_cnt_reg >= (RST_MS_SHORT - 1) * MS_CYCLES)
    else $error("reset pulse short");
  timeout_rst_a: assert property ($fell(watchdog_expired_n) |-> !reset_n) else $error("timeout no reset");
  cover property ($fell(watchdog_expired_n));
  cover property ($rose(reset_n));
  cover property (backup_active ##1 !backup_active);
  cover property (!timebase_select && $rose(reset_n));
endmodule

/* sim/supervisor_reset_watchdog_bench.sv */
// Self-checking bench for the supervisor reset watchdog
module supervisor_reset_watchdog_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, sl, bk, kick, kf, csi, pws, run, flt, tbs, tbl;
  logic ext_ck = 1'b0;
  logic rn, rh, lln, wen, cso, pwn;
  srw_pkg::srw_state_t st;
  int n_mismatch = 0;
  int check_count = 0;
  srw_supervisor #(.MS_CYCLES(4), .RST_MS_SHORT(5), .RST_MS_LONG(8), .WD_MS_LONG(40), .WD_MS_SHORT(10),
    .EXT_LONG(4), .EXT_SHORT(2), .EXT_RST(2)) dut (
    .clk(clk), .rst(rst), .supply_low(sl), .backup_active(bk), .watchdog_kick_in(kick),
    .watchdog_kick_float(kf), .chip_select_n_in(csi), .timebase_select(tbs), .timebase_input(tbs ? tbl : ext_ck),
    .power_warn_sense(pws), .reset_n(rn), .reset_hi(rh), .low_line_n(lln), .watchdog_expired_n(wen),
    .chip_select_n_out(cso), .power_warn_n(pwn), .state(st));
  srw_host_model host (.clk(clk), .run(run), .float_req(flt), .kick(kick), .kick_float(kf));
  // External timebase clock, one rising edge every two cycles
  always @(posedge clk) ext_ck <= #1 !ext_ck;
  function automatic logic exp_cs(logic low, logic b, logic cs);
    return (low || b) ? 1'b1 : cs;
  endfunction
  task automatic give_verdict();
    if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_sig(ref logic s, input logic v, input int lim);
    for (int i = 0; i < lim && s !== v; i++) begin
      @(posedge clk);
      #1;
    end
    chk(s, v);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #50us;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'hc2d43bbc));
    {rst, sl, bk, csi, pws, run, flt} = 7'b1001100;
    {tbs, tbl} = 2'b11;
    repeat (6) @(posedge clk);
    #1;
    chk({rn, rh, lln, cso, wen, pwn}, 8'h16);
    chk(st, srw_pkg::SRW_ST_RESET);
    rst = 1'b0;
    run = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(rn, 1'b0);
    wait_sig(rn, 1'b1, 100);
    for (int i = 0; i < 20; i++) begin
      csi = 1'($urandom);
      pws = 1'($urandom);
      @(posedge clk);
      #1;
      chk(cso, exp_cs(sl, bk, csi));
      chk(pwn, pws);
    end
    sl = 1'b1;
    @(posedge clk);
    #1;
    chk({rn, lln, cso, wen}, {3'b000, exp_cs(sl, bk, csi), 1'b1});
    sl = 1'b0;
    @(posedge clk);
    #1;
    chk({lln, rn}, 8'h2);
    wait_sig(rn, 1'b1, 100);
    run = 1'b0;
    wait_sig(wen, 1'b0, 300);
    chk(rn, 1'b0);
    run = 1'b1;
    wait_sig(wen, 1'b1, 40);
    wait_sig(rn, 1'b1, 100);
    flt = 1'b1;
    repeat (400) @(posedge clk);
    #1;
    chk({wen, rn}, 8'h3);
    flt = 1'b0;
    bk = 1'b1;
    csi = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({rn, lln, wen, cso, pwn}, 8'h6);
    chk(st, srw_pkg::SRW_ST_BACKUP);
    bk = 1'b0;
    tbl = 1'b0;
    run = 1'b0;
    wait_sig(rn, 1'b1, 100);
    chk(st, srw_pkg::SRW_ST_RUN);
    repeat (100) @(posedge clk);
    #1;
    chk({rn, wen}, 8'h3);
    wait_sig(wen, 1'b0, 100);
    chk(rn, 1'b0);
    run = 1'b1;
    wait_sig(wen, 1'b1, 40);
    wait_sig(rn, 1'b1, 100);
    repeat (40) @(posedge clk);
    #1;
    run = 1'b0;
    wait_sig(wen, 1'b0, 60);
    chk(st, srw_pkg::SRW_ST_RESET);
    tbs = 1'b0;
    sl = 1'b1;
    @(posedge clk);
    #1;
    sl = 1'b0;
    chk(wen, 1'b1);
    repeat (100) @(posedge clk);
    #1;
    chk(rn, 1'b0);
    wait_sig(rn, 1'b1, 200);
    repeat (300) @(posedge clk);
    #1;
    chk({rn, wen}, 8'h3);
    wait_sig(wen, 1'b0, 250);
    give_verdict();
  end
endmodule
bind srw_supervisor srw_supervisor_asserts #(.MS_CYCLES(MS_CYCLES), .RST_MS_SHORT(RST_MS_SHORT)) chk_i (
  .clk(clk), .rst(rst), .supply_low(supply_low), .backup_active(backup_active),
  .chip_select_n_in(chip_select_n_in), .timebase_select(timebase_select), .reset_n(reset_n),
  .reset_hi(reset_hi), .low_line_n(low_line_n), .watchdog_expired_n(watchdog_expired_n),
  .chip_select_n_out(chip_select_n_out));
